// ==== audio_dsp_pkg.sv ====
// Shared constants for the stereo codec digital audio processing core
package audio_dsp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CLOCK = 8'h00;
  localparam logic [7:0] OFS_FILTER = 8'h04;
  localparam logic [7:0] OFS_AGC_L = 8'h08;
  localparam logic [7:0] OFS_AGC_R = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COEF = 8'h80;
  localparam int COEF_WORDS = 29;
  // Clock register fields
  localparam int CLK_ADC_DIV = 0;
  localparam int CLK_DAC_DIV = 4;
  localparam int CLK_ADC_DUAL = 8;
  localparam int CLK_DAC_DUAL = 9;
  // Filter register fields
  localparam int FLT_HP_SEL = 0;
  localparam int FLT_HP_PROG = 4;
  localparam int FLT_EFF_EN = 6;
  localparam int FLT_EFF_DAC = 7;
  localparam int FLT_DEEMPH = 8;
  localparam int FLT_3D = 9;
  localparam int FLT_DEPTH = 16;
  // Gain control register fields
  localparam int AGC_EN = 0;
  localparam int AGC_ADV = 1;
  localparam int AGC_TARGET = 2;
  localparam int AGC_ATTACK = 5;
  localparam int AGC_DECAY = 8;
  localparam int AGC_MAXG = 11;
  localparam int AGC_THR = 18;
  localparam int AGC_HYST = 22;
  localparam int AGC_CLIP = 24;
  localparam int AGC_SDEB = 25;
  localparam int AGC_NDEB = 27;
  localparam int AGC_MULT = 29;
  // Status register fields
  localparam int ST_GATED = 16;
  localparam int ST_OVR = 18;
  localparam int ST_LEVEL = 20;
  // Coefficient word indices
  localparam int CI_EFF = 0;
  localparam int CI_HP = 20;
  localparam int CI_DE = 26;
  // Reset values
  localparam logic [31:0] RST_CLOCK = 32'h0000_0000;
  localparam logic [31:0] RST_FILTER = 32'h0000_0000;
  localparam logic [31:0] RST_AGC = 32'h0003_F810;
  localparam logic [6:0] RST_GAIN = 7'h00;
  localparam logic signed [15:0] Q14_ONE = 16'sh4000;
  localparam logic signed [15:0] Q14_NEG_ONE = 16'shC000;
  // Standard high-pass poles, written as a1 of y = ... - a1*y1
  localparam logic signed [15:0] HP_A1_1 = 16'shC010;
  localparam logic signed [15:0] HP_A1_2 = 16'shC040;
  localparam logic signed [15:0] HP_A1_3 = 16'shC100;
  localparam logic [15:0] CLIP_LEVEL = 16'h7FFF;
  localparam logic [15:0] TARGET_TOP = 16'h4000;
  localparam logic [15:0] TIME_STD_UNIT = 16'h0020;
  localparam logic [15:0] TIME_ADV_UNIT = 16'h0010;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 32;
endpackage

// ==== audio_dsp_core.sv ====
// Digital audio processing core with APB registers and record FIFO
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];
  assign level = cnt_r;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= AW'(wp_r + 1'b1);
      if (pop) rp_r <= AW'(rp_r + 1'b1);
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule // sample_fifo

module audio_dsp_core
  import audio_dsp_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reference sample rate tick
  input wire logic fsref_tick,
  // ADC words and analog gain
  input wire logic signed [15:0] adc_l_in,
  input wire logic signed [15:0] adc_r_in,
  output logic [6:0] pga_gain_l,
  output logic [6:0] pga_gain_r,
  // Playback words from the serial side
  input wire logic signed [15:0] pb_l_in,
  input wire logic signed [15:0] pb_r_in,
  // DAC words
  output logic signed [15:0] dac_l,
  output logic signed [15:0] dac_r,
  output logic dac_valid,
  // Record words to the serial side, {left, right}
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [31:0] rec_data
);
  import audio_dsp_pkg::*;

  default clocking cb_pclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sd32767) return 16'sh7FFF;
    if (v < -40'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction

  function automatic logic signed [15:0] biquad(
      input logic signed [15:0] x, x1, x2, y1, y2, b0, b1, b2, a1, a2);
    logic signed [39:0] acc;
    acc = b0 * x + b1 * x1 + b2 * x2 - a1 * y1 - a2 * y2;
    return sat16(acc >>> 14);
  endfunction

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    return v[15] ? 16'(~v + 1'b1) : 16'(v);
  endfunction

  function automatic logic [15:0] agc_time(input logic adv,
      input logic [2:0] code, input logic [1:0] mult);
    if (adv) return 16'(TIME_ADV_UNIT * (code + 1'b1)) << mult;
    return TIME_STD_UNIT << code;
  endfunction

  // Five bits, so a factor field of 15 still divides by 16
  function automatic logic [4:0] tick_div(input logic [3:0] f,
      input logic dual);
    logic [4:0] d;
    d = 5'(f) + 5'h1;
    if (dual) d = (d >> 1) == 5'h0 ? 5'h1 : d >> 1;
    return d;
  endfunction

  logic [31:0] cfg_clk_r;
  logic [31:0] cfg_flt_r;
  logic [31:0] cfg_agc_r [2];
  logic signed [15:0] coef_r [32];
  logic [3:0] adc_cnt_r;
  logic [3:0] dac_cnt_r;
  logic adc_tick_r;
  logic dac_tick_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic ovr_r;
  logic [6:0] gain_r [2];
  logic gated_r [2];
  logic [15:0] atk_cnt_r [2];
  logic [15:0] dec_cnt_r [2];
  logic [7:0] deb_cnt_r [2];
  logic signed [15:0] hx1_r [2];
  logic signed [15:0] hy1_r [2];
  logic signed [15:0] dx1_r [2];
  logic signed [15:0] dy1_r [2];
  logic signed [15:0] bx1_r [4];
  logic signed [15:0] bx2_r [4];
  logic signed [15:0] by1_r [4];
  logic signed [15:0] by2_r [4];
  logic signed [15:0] dac_l_r;
  logic signed [15:0] dac_r_r;
  logic dac_valid_r;
  logic [31:0] rec_word;
  logic fifo_in_ready;
  logic [3:0] fifo_level;
  logic adc_take;
  logic eff_take;
  logic wr_en;
  logic signed [15:0] ax [2];
  logic signed [15:0] px [2];
  logic signed [15:0] hp_y [2];
  logic signed [15:0] eff_in [2];
  logic signed [15:0] bx [4];
  logic signed [15:0] by [4];
  logic signed [15:0] eff_y [2];
  logic signed [15:0] rec_y [2];
  logic signed [15:0] pm_y [2];
  logic signed [15:0] de_y [2];

  wire eff_en = cfg_flt_r[FLT_EFF_EN];
  wire eff_dac = cfg_flt_r[FLT_EFF_DAC];
  wire td_en = cfg_flt_r[FLT_3D];
  assign ax[0] = adc_l_in;
  assign ax[1] = adc_r_in;
  assign px[0] = pb_l_in;
  assign px[1] = pb_r_in;
  // Record stalls while the FIFO is full, so filter state stays coherent
  assign adc_take = adc_tick_r & fifo_in_ready;
  assign eff_take = eff_dac ? dac_tick_r : adc_take;
  assign wr_en = psel & penable & pready_r & pwrite;

  // Sample rate ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_cnt_r <= '0;
      dac_cnt_r <= '0;
      adc_tick_r <= 1'b0;
      dac_tick_r <= 1'b0;
    end else begin
      adc_tick_r <= 1'b0;
      dac_tick_r <= 1'b0;
      if (fsref_tick) begin
        if (adc_cnt_r + 1'b1 >= tick_div(cfg_clk_r[CLK_ADC_DIV +: 4],
            cfg_clk_r[CLK_ADC_DUAL])) begin
          adc_cnt_r <= '0;
          adc_tick_r <= 1'b1;
        end else adc_cnt_r <= adc_cnt_r + 1'b1;
        if (dac_cnt_r + 1'b1 >= tick_div(cfg_clk_r[CLK_DAC_DIV +: 4],
            cfg_clk_r[CLK_DAC_DUAL])) begin
          dac_cnt_r <= '0;
          dac_tick_r <= 1'b1;
        end else dac_cnt_r <= dac_cnt_r + 1'b1;
      end
    end
  end

  // Datapath, one sample per tick with fixed latency
  always_comb begin
    logic signed [15:0] side;
    logic signed [15:0] a1;
    logic signed [39:0] wide;
    a1 = HP_A1_1;
    wide = '0;
    side = 16'((ax[0] >>> 1) - (ax[1] >>> 1));
    if (eff_dac) side = 16'((px[0] >>> 1) - (px[1] >>> 1));
    for (int c = 0; c < 2; c++) begin
      a1 = HP_A1_1;
      if (cfg_flt_r[FLT_HP_SEL + 2*c +: 2] == 2'd2) a1 = HP_A1_2;
      if (cfg_flt_r[FLT_HP_SEL + 2*c +: 2] == 2'd3) a1 = HP_A1_3;
      if (cfg_flt_r[FLT_HP_PROG + c])
        hp_y[c] = biquad(ax[c], hx1_r[c], 16'sh0, hy1_r[c], 16'sh0,
          coef_r[CI_HP + 3*c], coef_r[CI_HP + 3*c + 1], 16'sh0,
          coef_r[CI_HP + 3*c + 2], 16'sh0);
      else if (cfg_flt_r[FLT_HP_SEL + 2*c +: 2] != 2'd0)
        hp_y[c] = biquad(ax[c], hx1_r[c], 16'sh0, hy1_r[c], 16'sh0,
          Q14_ONE, Q14_NEG_ONE, 16'sh0, a1, 16'sh0);
      else hp_y[c] = ax[c];
      eff_in[c] = eff_dac ? px[c] : hp_y[c];
      // 3D mode runs the left sections on the side signal
      bx[2*c] = td_en ? side : eff_in[c];
      for (int s = 0; s < 2; s++) begin
        if (s == 1) bx[2*c+1] = by[2*c];
        by[2*c+s] = biquad(bx[2*c+s], bx1_r[2*c+s], bx2_r[2*c+s],
          by1_r[2*c+s], by2_r[2*c+s], coef_r[CI_EFF + 10*c + 5*s],
          coef_r[CI_EFF + 10*c + 5*s + 1], coef_r[CI_EFF + 10*c + 5*s + 2],
          coef_r[CI_EFF + 10*c + 5*s + 3],
          coef_r[CI_EFF + 10*c + 5*s + 4]);
      end
    end
    for (int c = 0; c < 2; c++) begin
      wide = $signed({1'b0, cfg_flt_r[FLT_DEPTH +: 8]}) * by[1];
      if (!td_en) eff_y[c] = by[2*c+1];
      else if (c == 0) eff_y[c] = sat16(40'(eff_in[0]) + (wide >>> 8));
      else eff_y[c] = sat16(40'(eff_in[1]) - (wide >>> 8));
      rec_y[c] = (eff_en && !eff_dac) ? eff_y[c] : hp_y[c];
      pm_y[c] = (eff_en && eff_dac) ? eff_y[c] : px[c];
      de_y[c] = cfg_flt_r[FLT_DEEMPH] ? biquad(pm_y[c], dx1_r[c], 16'sh0,
        dy1_r[c], 16'sh0, coef_r[CI_DE], coef_r[CI_DE + 1], 16'sh0,
        coef_r[CI_DE + 2], 16'sh0) : pm_y[c];
    end
    rec_word = {rec_y[0], rec_y[1]};
  end

  // Filter state, advanced only on the owning path's sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        bx1_r[i] <= '0;
        bx2_r[i] <= '0;
        by1_r[i] <= '0;
        by2_r[i] <= '0;
      end
      for (int c = 0; c < 2; c++) begin
        hx1_r[c] <= '0;
        hy1_r[c] <= '0;
        dx1_r[c] <= '0;
        dy1_r[c] <= '0;
      end
    end else begin
      if (eff_take) begin
        for (int i = 0; i < 4; i++) begin
          bx1_r[i] <= bx[i];
          bx2_r[i] <= bx1_r[i];
          by1_r[i] <= by[i];
          by2_r[i] <= by1_r[i];
        end
      end
      for (int c = 0; c < 2; c++) begin
        if (adc_take) begin
          hx1_r[c] <= ax[c];
          hy1_r[c] <= hp_y[c];
        end
        if (dac_tick_r) begin
          dx1_r[c] <= pm_y[c];
          dy1_r[c] <= de_y[c];
        end
      end
    end
  end

  // DAC words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_l_r <= '0;
      dac_r_r <= '0;
      dac_valid_r <= 1'b0;
    end else begin
      dac_valid_r <= dac_tick_r;
      if (dac_tick_r) begin
        dac_l_r <= de_y[0];
        dac_r_r <= de_y[1];
      end
    end
  end

  // Gain control and noise gate per channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        gain_r[c] <= RST_GAIN;
        gated_r[c] <= 1'b0;
        atk_cnt_r[c] <= '0;
        dec_cnt_r[c] <= '0;
        deb_cnt_r[c] <= '0;
      end
    end else if (adc_take) begin
      for (int c = 0; c < 2; c++) begin
        logic [31:0] g;
        logic [15:0] lvl;
        logic [15:0] thr;
        g = cfg_agc_r[c];
        lvl = mag(hp_y[c]);
        thr = CLIP_LEVEL >> g[AGC_THR +: 4];
        // Gate opens at or above threshold, closes below threshold shifted up by hysteresis
        if (gated_r[c] == (lvl >= (thr << g[AGC_HYST +: 2]))
            || !gated_r[c] == (lvl < thr)) begin
          if (deb_cnt_r[c] >= 8'(1 << (2 * (gated_r[c] ?
              g[AGC_SDEB +: 2] : g[AGC_NDEB +: 2])))) begin
            gated_r[c] <= !gated_r[c];
            deb_cnt_r[c] <= '0;
          end else deb_cnt_r[c] <= deb_cnt_r[c] + 1'b1;
        end else deb_cnt_r[c] <= '0;
        if (!g[AGC_EN] || gated_r[c]) begin
          atk_cnt_r[c] <= '0;
          dec_cnt_r[c] <= '0;
        end else if (g[AGC_CLIP] && lvl >= CLIP_LEVEL) begin
          if (gain_r[c] != 7'd0) gain_r[c] <= gain_r[c] - 1'b1;
          atk_cnt_r[c] <= '0;
        end else if (lvl > (TARGET_TOP >> g[AGC_TARGET +: 3])) begin
          dec_cnt_r[c] <= '0;
          if (atk_cnt_r[c] + 1'b1 >= agc_time(g[AGC_ADV],
              g[AGC_ATTACK +: 3], g[AGC_MULT +: 2])) begin
            atk_cnt_r[c] <= '0;
            if (gain_r[c] != 7'd0) gain_r[c] <= gain_r[c] - 1'b1;
          end else atk_cnt_r[c] <= atk_cnt_r[c] + 1'b1;
        end else begin
          atk_cnt_r[c] <= '0;
          if (dec_cnt_r[c] + 1'b1 >= agc_time(g[AGC_ADV],
              g[AGC_DECAY +: 3], g[AGC_MULT +: 2])) begin
            dec_cnt_r[c] <= '0;
            if (gain_r[c] < g[AGC_MAXG +: 7]) gain_r[c] <= gain_r[c] + 1'b1;
            else gain_r[c] <= g[AGC_MAXG +: 7];
          end else dec_cnt_r[c] <= dec_cnt_r[c] + 1'b1;
        end
      end
    end
  end

  // APB: answer in the first access cycle, unmapped gives pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= psel & ~penable;
      if (psel && !penable) begin
        pslverr_r <= 1'b0;
        prdata_r <= '0;
        if (paddr[7]) begin
          if (int'(paddr[6:2]) < COEF_WORDS)
            prdata_r <= {16'h0000, coef_r[paddr[6:2]]};
          else pslverr_r <= 1'b1;
        end else begin
          unique case (paddr)
            OFS_CLOCK: prdata_r <= cfg_clk_r;
            OFS_FILTER: prdata_r <= cfg_flt_r;
            OFS_AGC_L: prdata_r <= cfg_agc_r[0];
            OFS_AGC_R: prdata_r <= cfg_agc_r[1];
            OFS_STATUS: prdata_r <= (32'(gain_r[0])) | (32'(gain_r[1]) << 8)
              | (32'(gated_r[0]) << ST_GATED)
              | (32'(gated_r[1]) << (ST_GATED + 1))
              | (32'(ovr_r) << ST_OVR) | (32'(fifo_level) << ST_LEVEL);
            default: pslverr_r <= 1'b1;
          endcase
        end
      end
    end
  end

  // Configuration and coefficient storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_clk_r <= RST_CLOCK;
      cfg_flt_r <= RST_FILTER;
      cfg_agc_r[0] <= RST_AGC;
      cfg_agc_r[1] <= RST_AGC;
      for (int i = 0; i < 32; i++)
        coef_r[i] <= ((i % 5 == 0 && i < CI_HP) || i == CI_DE) ? Q14_ONE : '0;
    end else if (wr_en) begin
      // Coefficients land regardless of filter enables
      if (paddr[7] && int'(paddr[6:2]) < COEF_WORDS)
        coef_r[paddr[6:2]] <= pwdata[15:0];
      if (paddr == OFS_CLOCK) cfg_clk_r <= pwdata;
      if (paddr == OFS_FILTER) cfg_flt_r <= pwdata;
      if (paddr == OFS_AGC_L) cfg_agc_r[0] <= pwdata;
      if (paddr == OFS_AGC_R) cfg_agc_r[1] <= pwdata;
    end
  end

  // Sticky overrun, set wins over the read-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ovr_r <= 1'b0;
    else if (adc_tick_r && !fifo_in_ready) ovr_r <= 1'b1;
    else if (psel && penable && pready_r && !pwrite && paddr == OFS_STATUS)
      ovr_r <= 1'b0;
  end

  sample_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rec_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(adc_tick_r),
    .in_ready(fifo_in_ready),
    .in_data(rec_word),
    .out_valid(rec_valid),
    .out_ready(rec_ready),
    .out_data(rec_data),
    .level(fifo_level)
  );

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pga_gain_l = gain_r[0];
  assign pga_gain_r = gain_r[1];
  assign dac_l = dac_l_r;
  assign dac_r = dac_r_r;
  assign dac_valid = dac_valid_r;

  chk_apb_answer: assert property (
    psel && !penable |=> pready) else $error("apb answer late");
  chk_adc_rate_gap: assert property (
    adc_tick_r && cfg_clk_r[CLK_ADC_DIV +: 4] == 4'h1
      && !cfg_clk_r[CLK_ADC_DUAL] && $stable(cfg_clk_r) |=> !adc_tick_r)
    else $error("adc tick too soon");
  chk_dac_dual_rate: assert property (
    fsref_tick && cfg_clk_r[CLK_DAC_DIV +: 4] == 4'h1
      && cfg_clk_r[CLK_DAC_DUAL] |=> dac_tick_r)
    else $error("dual rate tick missing");
  chk_gain_ceiling: assert property (
    gain_r[0] > $past(gain_r[0])
      |-> gain_r[0] <= $past(cfg_agc_r[0][AGC_MAXG +: 7]))
    else $error("gain over max");
  chk_gate_hold: assert property (
    gated_r[0] |=> $stable(gain_r[0])) else $error("gain moved while gated");
  chk_rec_passthru: assert property (
    adc_take && cfg_flt_r[5:0] == 6'h00 && !(eff_en && !eff_dac)
      |-> rec_word == {adc_l_in, adc_r_in}) else $error("record not passed");
  chk_dac_passthru: assert property (
    dac_tick_r && !eff_en && !cfg_flt_r[FLT_DEEMPH]
      |=> dac_valid && dac_l == $past(pb_l_in)) else $error("dac not passed");
  chk_effect_excl: assert property (
    eff_en && eff_dac |-> rec_y[0] == hp_y[0] && rec_y[1] == hp_y[1])
    else $error("effects on both paths");
  chk_coef_store: assert property (
    wr_en && paddr == OFS_COEF |=> coef_r[0] == $past(pwdata[15:0]))
    else $error("coefficient not stored");
endmodule // audio_dsp_core

// ==== pcm_host_model.sv ====
// Host-side model: reference tick, converter words and record drain
`timescale 1ns/1ps
module pcm_host_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls
  input wire logic tick_en,
  input wire logic drain_en,
  // Stream to and from the core
  output logic fsref_tick,
  output logic signed [15:0] adc_l_in,
  output logic signed [15:0] adc_r_in,
  output logic signed [15:0] pb_l_in,
  output logic signed [15:0] pb_r_in,
  output logic rec_ready
);
  integer seed = 16193;
  logic [3:0] phase_r = 4'h0;
  initial begin
    {fsref_tick, rec_ready} = 2'b00;
    {adc_l_in, adc_r_in, pb_l_in, pb_r_in} = 64'h0;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 4'h0;
      fsref_tick <= 1'b0;
      rec_ready <= 1'b0;
    end else begin
      phase_r <= phase_r + 4'h1;
      // One tick every 16 cycles keeps the reference rate steady
      fsref_tick <= tick_en && phase_r == 4'h0;
      // Words change well clear of the sampling tick
      if (phase_r == 4'h6) begin
        adc_l_in <= 16'($random(seed));
        adc_r_in <= 16'($random(seed));
        pb_l_in <= 16'($random(seed));
        pb_r_in <= 16'($random(seed));
      end
      // Random stalls on the record side
      rec_ready <= drain_en & 1'($random(seed));
    end
  end
endmodule // pcm_host_model

// ==== codec_digital_audio_processing_tb.sv ====
// Self-checking testbench for the digital audio processing core
`timescale 1ns/1ps
module codec_digital_audio_processing_tb;
  import audio_dsp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rec_data, rd;
  logic pready, pslverr, rec_valid, rec_ready, dac_valid, fsref_tick, er;
  logic signed [15:0] adc_l_in, adc_r_in, pb_l_in, pb_r_in, dac_l, dac_r;
  logic [6:0] pga_gain_l, pga_gain_r;
  logic tick_en = 0, drain_en = 0, track = 1;
  int fails = 0, n_checks = 0, mode = 0, nt = 0, npop = 0, cyc = 0;
  int hx1 = 0, hy1 = 0, hp, hl, hy, t;
  logic [31:0] rq[$], dq[$];

  always #2 pclk = ~pclk;

  audio_dsp_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .fsref_tick, .adc_l_in, .adc_r_in,
    .pga_gain_l, .pga_gain_r, .pb_l_in, .pb_r_in, .dac_l, .dac_r,
    .dac_valid, .rec_valid, .rec_ready, .rec_data);
  pcm_host_model i_host (.pclk, .presetn, .tick_en, .drain_en, .fsref_tick,
    .adc_l_in, .adc_r_in, .pb_l_in, .pb_r_in, .rec_ready);

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic int sat(input int v);
    return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
  endfunction

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) fails++;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  task run(input int n);
    nt = 0;
    tick_en <= 1'b1;
    wait (nt >= n);
    @(posedge pclk);
    tick_en <= 1'b0;
    repeat (60) @(posedge pclk);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Reference model: words due at each reference tick
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      complete_run();
    end
    if (fsref_tick === 1'b1) begin
      nt++;
      // Right high-pass at the first corner, state kept as integers
      hp = adc_r_in;
      if (mode == 3)
        hp = sat((int'(Q14_ONE) * (adc_r_in - hx1)
          - int'(HP_A1_1) * hy1) >>> 14);
      hl = mode == 1 ? adc_l_in >>> 1 : (mode == 3 ? 0 : adc_l_in);
      hy = hp;
      if (mode == 4) begin
        // Side signal halved by the first stage, then depth 128 of 256
        t = ((((adc_l_in >>> 1) - (adc_r_in >>> 1)) >>> 1) * 128) >>> 8;
        hl = sat(adc_l_in + t);
        hy = sat(adc_r_in - t);
      end
      // A dropped sample leaves the filter state alone
      if (!track || rq.size() < 8) begin
        hx1 = adc_r_in;
        hy1 = hp;
      end
      if (track && rq.size() < 8)
        rq.push_back({16'(hl), 16'(hy)});
      dq.push_back({mode == 2 || mode == 3 ? pb_l_in >>> 1 : pb_l_in,
        mode == 3 ? pb_r_in >>> 1 : pb_r_in});
    end
    if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
      npop++;
      if (track) chk("rec_data", rq.pop_front(), rec_data);
    end
    if (dac_valid === 1'b1)
      chk("dac", dq.pop_front(), {dac_l, dac_r});
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_CLOCK, RST_CLOCK, "clock");
    rdchk(OFS_FILTER, RST_FILTER, "filter");
    rdchk(OFS_COEF, 32'h0000_4000, "coef");
    apb(1'b1, OFS_AGC_L, 32'h0003_F812);
    rdchk(OFS_AGC_L, 32'h0003_F812, "agc_l");
    rdchk(OFS_AGC_R, RST_AGC, "agc_r");
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0, er});
    $display("test regs done");
    drain_en <= 1'b1;
    run(10);
    $display("test plain done");
    // Coefficient written while effects are off, so no change yet
    apb(1'b1, OFS_COEF, 32'h0000_2000);
    run(6);
    $display("test stored done");
    apb(1'b1, OFS_FILTER, 32'h0000_0040);
    mode = 1;
    run(10);
    apb(1'b1, OFS_FILTER, 32'h0000_00C0);
    mode = 2;
    run(10);
    apb(1'b1, OFS_FILTER, 32'h0080_0240);
    mode = 4;
    run(6);
    $display("test effects done");
    apb(1'b1, OFS_FILTER, 32'h0000_0000);
    mode = 0;
    track = 0;
    apb(1'b1, OFS_CLOCK, 32'h0000_0001);
    npop = 0;
    run(8);
    chk("div_pops", 32'd4, npop);
    apb(1'b1, OFS_CLOCK, 32'h0000_0311);
    npop = 0;
    run(8);
    chk("dual_pops", 32'd8, npop);
    $display("test rates done");
    apb(1'b1, OFS_CLOCK, 32'h0000_0000);
    track = 1;
    apb(1'b1, OFS_COEF + 8'(4 * CI_HP), 32'h0000_0000);
    apb(1'b1, OFS_COEF + 8'(4 * CI_DE), 32'h0000_2000);
    apb(1'b1, OFS_FILTER, 32'h0000_0114);
    mode = 3;
    // Quiet left input: one gain step per 16 samples, gate held open
    apb(1'b1, OFS_AGC_L, 32'h003F_F813);
    run(40);
    chk("gain_l", 40 / TIME_ADV_UNIT, pga_gain_l);
    chk("gain_r", RST_GAIN, pga_gain_r);
    apb(1'b1, OFS_AGC_L, 32'h0003_F813);
    run(10);
    chk("gain_hold", 40 / TIME_ADV_UNIT, pga_gain_l);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("gated_l", 32'h0001_0000, rd & 32'h0001_0000);
    $display("test gain done");
    drain_en <= 1'b0;
    run(10);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("status", 32'h0084_0000, rd & 32'h00F4_0000);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("status2", 32'h0080_0000, rd & 32'h00F4_0000);
    drain_en <= 1'b1;
    repeat (60) @(posedge pclk);
    chk("rec_left", 32'd0, rq.size());
    chk("dac_left", 32'd0, dq.size());
    $display("test overrun done");
    complete_run();
  end
endmodule // codec_digital_audio_processing_tb
